// File: irq_ctrl_defs.svh
// Purpose: Offsets, field positions, masks and reset values of the interrupt block
// Assumes: 32-bit APB, one aligned word per 8-bit register
// Notes:   Constants only; types live in irq_ctrl_pkg
`ifndef IRQ_CTRL_DEFS_SVH
`define IRQ_CTRL_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_EXT_EDGE_SELECT 12'h000
`define OFS_IRQ_CONTROL_0   12'h004
`define OFS_IRQ_CONTROL_1   12'h008
`define OFS_IRQ_CONTROL_2   12'h00c
`define OFS_IRQ_CONTROL_3   12'h010
`define OFS_GROUP_IRQ_0     12'h014
`define OFS_GROUP_IRQ_1     12'h018
`define OFS_GROUP_IRQ_2     12'h01c

// Register indices, byte address over four
`define IDX_EDGE 3'd0
`define IDX_C0   3'd1
`define IDX_C1   3'd2
`define IDX_C2   3'd3
`define IDX_C3   3'd4
`define IDX_G0   3'd5
`define IDX_G1   3'd6
`define IDX_G2   3'd7

// ----------------------------------------
// Implemented-bit masks and reset value
// ----------------------------------------
`define MASK_EDGE 8'h0f
`define MASK_C0   8'h7f
`define MASK_C1   8'hff
`define MASK_C2   8'hff
`define MASK_C3   8'h11
`define MASK_G0   8'h33
`define MASK_G1   8'hff
`define MASK_G2   8'h33
`define REG_RESET 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define POS_PIN0_SEL    0
`define POS_PIN1_SEL    2
`define POS_GLOBAL_EN   0
`define POS_PIN0_EN     1
`define POS_CMP_EN      2
`define POS_GRP0_EN     3
`define POS_PIN0_FLAG   4
`define POS_CMP_FLAG    5
`define POS_GRP0_FLAG   6
`define POS_GRP1_EN     0
`define POS_GRP2_EN     1
`define POS_ADC_EN      2
`define POS_TICK0_EN    3
`define POS_GRP1_FLAG   4
`define POS_GRP2_FLAG   5
`define POS_ADC_FLAG    6
`define POS_TICK0_FLAG  7
`define POS_TICK1_EN    0
`define POS_PIN1_EN     1
`define POS_SIM_EN      2
`define POS_UART_EN     3
`define POS_TICK1_FLAG  4
`define POS_PIN1_FLAG   5
`define POS_SIM_FLAG    6
`define POS_UART_FLAG   7
`define POS_NFC_EN      0
`define POS_NFC_FLAG    4
`define POS_SUB_FLAGS   4

// Edge-select encodings
`define EDGE_OFF     2'b00
`define EDGE_RISE    2'b01
`define EDGE_FALL    2'b10
`define EDGE_BOTH    2'b11

`endif

// File: irq_ctrl_pkg.sv
// Purpose: Types shared by the interrupt block and its bench
// Assumes: irq_ctrl_defs.svh holds the numbers
// Notes:   Vector order is also the fixed priority, lowest index first
package irq_ctrl_pkg;

	// Peripheral event pulses, one cycle each
	typedef struct packed {
		logic cmp;
		logic adc;
		logic tick0;
		logic tick1;
		logic sim;
		logic uart;
		logic nfc;
		logic stm_p;
		logic stm_a;
		logic ptm_p;
		logic ptm_a;
		logic ctm_p;
		logic ctm_a;
		logic eeprom;
		logic lvd;
	} src_events_t;

	typedef enum logic [3:0] {
		VEC_PIN0,
		VEC_CMP,
		VEC_GRP0,
		VEC_GRP1,
		VEC_GRP2,
		VEC_ADC,
		VEC_TICK0,
		VEC_TICK1,
		VEC_PIN1,
		VEC_SIM,
		VEC_UART,
		VEC_NFC
	} vec_t;

	typedef logic [7:0] reg8_t;

endpackage : irq_ctrl_pkg

// File: irq_ctrl.sv
// Purpose: Interrupt flags, enables, edge select and vector request with APB access
// Assumes: Pins and events synchronous to pclk; sequencer acks one vector at a time
// Notes:   Zero APB wait states; one more after a setup cycle frozen by ce
//
// How it works
// - Pin 1 edge field: 00 off, 01 rising, 10 falling, 11 both.
// - Pin 0 edge field in edge register bits 1:0, same encoding.
// - Control 0 bit 0 is global enable; zero blocks every delivery.
// - Each source has a writable enable and a request flag, 1 meaning active.
// - Comparator flag control 0 bit 5, enable bit 2.
// - Pin 0 flag control 0 bit 4, enable bit 1.
// - Group 0 flag control 0 bit 6, enable bit 3; bit 7 unimplemented.
// - Tick 0 flag control 1 bit 7, enable bit 3.
// - ADC flag control 1 bit 6, enable bit 2.
// - Group 2 flag control 1 bit 5, enable bit 1.
// - Group 1 flag control 1 bit 4, enable bit 0.
// - Timer, EEPROM and LVD sub-flags live in three group registers feeding groups.
// - Internal requests from timers, comparator, ticks, LVD, EEPROM, SIM, UART, NFC, ADC.
// - Qualifying transitions on two external pins set their own flags.
// - Edge register bits 7:4 unimplemented, read zero.
// - Flags set even while disabled; no vector then.
// - Servicing clears global enable; new events still set flags.
// - Servicing a pin vector also clears that pin's flag.
// - Any set flag in control 0 to 3 raises wake regardless of enables; group sub-flags only through their group flag.
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
`include "irq_ctrl_defs.svh"

module irq_ctrl
	import irq_ctrl_pkg::*;
(
	input  wire logic        pclk,       // System clock, 50 MHz
	input  wire logic        presetn,    // Async reset, active low
	input  wire logic        ce,         // Clock enable, freezes state when low
	input  wire logic        psel,       // APB select
	input  wire logic        penable,    // APB access phase
	input  wire logic        pwrite,     // APB write
	input  wire logic [11:0] paddr,      // APB byte address
	input  wire logic [31:0] pwdata,     // APB write data
	output logic      [31:0] prdata,     // APB read data
	output logic             pready,     // APB ready
	output logic             pslverr,    // APB error on unmapped address
	input  wire logic [1:0]  ext_irq_pin,// External interrupt pins
	input  src_events_t      events,     // Peripheral event pulses
	output logic             irq_req,    // Vector request to sequencer
	output vec_t             irq_vec,    // Vector being requested
	input  wire logic        irq_ack,    // Sequencer takes the vector
	output logic             wake        // Any flag set in control 0 to 3
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	reg8_t       regs_q [8];
	reg8_t       regs_d [8];
	logic [1:0]  pin_prev_q;
	logic        prev_ok_q;
	logic [31:0] prdata_q, prdata_d;
	logic        slverr_q, slverr_d;
	logic        req_q, req_d;
	vec_t        vec_q, vec_d;
	logic        wake_q, wake_d;
	// Set once read data is held for the running transfer
	logic        fresh_q, fresh_d;

	logic        mapped;
	logic [2:0]  idx;
	logic        wr_en;
	logic [1:0]  pin_hit;
	logic [11:0] pend;
	logic [11:0] pend_now;

	assign idx     = paddr[4:2];
	assign mapped  = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'b00);
	assign pready  = penable & ce & fresh_q;
	assign wr_en   = psel & penable & pwrite & ce & mapped & fresh_q;
	assign prdata  = prdata_q;
	assign pslverr = slverr_q;
	assign irq_req = req_q;
	assign irq_vec = vec_q;
	assign wake    = wake_q;

	function automatic reg8_t reg_mask(input logic [2:0] i);
		unique case (i)
			`IDX_EDGE: reg_mask = `MASK_EDGE;
			`IDX_C0:   reg_mask = `MASK_C0;
			`IDX_C1:   reg_mask = `MASK_C1;
			`IDX_C2:   reg_mask = `MASK_C2;
			`IDX_C3:   reg_mask = `MASK_C3;
			`IDX_G0:   reg_mask = `MASK_G0;
			`IDX_G1:   reg_mask = `MASK_G1;
			`IDX_G2:   reg_mask = `MASK_G2;
		endcase
	endfunction : reg_mask

	function automatic logic edge_hit(input logic [1:0] sel, input logic prev,
		input logic now);
		unique case (sel)
			`EDGE_OFF:  edge_hit = 1'b0;
			`EDGE_RISE: edge_hit = ~prev & now;
			`EDGE_FALL: edge_hit = prev & ~now;
			`EDGE_BOTH: edge_hit = prev ^ now;
		endcase
	endfunction : edge_hit

	// Enabled pending sources, in vector order
	function automatic logic [11:0] pending(input reg8_t c0, input reg8_t c1,
		input reg8_t c2, input reg8_t c3);
		pending = {
			c3[`POS_NFC_FLAG]   & c3[`POS_NFC_EN],
			c2[`POS_UART_FLAG]  & c2[`POS_UART_EN],
			c2[`POS_SIM_FLAG]   & c2[`POS_SIM_EN],
			c2[`POS_PIN1_FLAG]  & c2[`POS_PIN1_EN],
			c2[`POS_TICK1_FLAG] & c2[`POS_TICK1_EN],
			c1[`POS_TICK0_FLAG] & c1[`POS_TICK0_EN],
			c1[`POS_ADC_FLAG]   & c1[`POS_ADC_EN],
			c1[`POS_GRP2_FLAG]  & c1[`POS_GRP2_EN],
			c1[`POS_GRP1_FLAG]  & c1[`POS_GRP1_EN],
			c0[`POS_GRP0_FLAG]  & c0[`POS_GRP0_EN],
			c0[`POS_CMP_FLAG]   & c0[`POS_CMP_EN],
			c0[`POS_PIN0_FLAG]  & c0[`POS_PIN0_EN]};
	endfunction : pending

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			regs_d[i] = regs_q[i];
		end
		prdata_d = prdata_q;
		slverr_d = slverr_q;
		fresh_d  = psel & ~(penable & fresh_q);

		// First running cycle of a transfer captures read data; a setup frozen
		// by ce costs one wait state rather than handing back stale data
		if (psel && !(penable && fresh_q)) begin
			prdata_d = 32'h0000_0000;
			slverr_d = ~mapped;
			if (mapped) begin
				prdata_d[7:0] = regs_q[idx] & reg_mask(idx);
			end
		end

		// Software write first, so hardware sets below win over a clear
		if (wr_en) begin
			regs_d[idx] = pwdata[7:0] & reg_mask(idx);
		end

		// Service: global enable off, pin flag cleared by hardware
		if (irq_ack && req_q) begin
			regs_d[`IDX_C0][`POS_GLOBAL_EN] = 1'b0;
			if (vec_q == VEC_PIN0) begin
				regs_d[`IDX_C0][`POS_PIN0_FLAG] = 1'b0;
			end
			if (vec_q == VEC_PIN1) begin
				regs_d[`IDX_C2][`POS_PIN1_FLAG] = 1'b0;
			end
		end

		// Event sets, regardless of enables
		pin_hit[0] = prev_ok_q & edge_hit(regs_q[`IDX_EDGE][`POS_PIN0_SEL +: 2],
			pin_prev_q[0], ext_irq_pin[0]);
		pin_hit[1] = prev_ok_q & edge_hit(regs_q[`IDX_EDGE][`POS_PIN1_SEL +: 2],
			pin_prev_q[1], ext_irq_pin[1]);
		if (pin_hit[0]) regs_d[`IDX_C0][`POS_PIN0_FLAG] = 1'b1;
		if (pin_hit[1]) regs_d[`IDX_C2][`POS_PIN1_FLAG] = 1'b1;
		if (events.cmp)   regs_d[`IDX_C0][`POS_CMP_FLAG]   = 1'b1;
		if (events.adc)   regs_d[`IDX_C1][`POS_ADC_FLAG]   = 1'b1;
		if (events.tick0) regs_d[`IDX_C1][`POS_TICK0_FLAG] = 1'b1;
		if (events.tick1) regs_d[`IDX_C2][`POS_TICK1_FLAG] = 1'b1;
		if (events.sim)   regs_d[`IDX_C2][`POS_SIM_FLAG]   = 1'b1;
		if (events.uart)  regs_d[`IDX_C2][`POS_UART_FLAG]  = 1'b1;
		if (events.nfc)   regs_d[`IDX_C3][`POS_NFC_FLAG]   = 1'b1;
		if (events.stm_p) regs_d[`IDX_G0][4] = 1'b1;
		if (events.stm_a) regs_d[`IDX_G0][5] = 1'b1;
		if (events.ptm_p) regs_d[`IDX_G1][4] = 1'b1;
		if (events.ptm_a) regs_d[`IDX_G1][5] = 1'b1;
		if (events.ctm_p) regs_d[`IDX_G1][6] = 1'b1;
		if (events.ctm_a) regs_d[`IDX_G1][7] = 1'b1;
		if (events.lvd)    regs_d[`IDX_G2][4] = 1'b1;
		if (events.eeprom) regs_d[`IDX_G2][5] = 1'b1;

		// Group flags follow enabled sub-flags; software clear only sticks once idle
		if (|(regs_q[`IDX_G0][`POS_SUB_FLAGS +: 4] & regs_q[`IDX_G0][3:0])) begin
			regs_d[`IDX_C0][`POS_GRP0_FLAG] = 1'b1;
		end
		if (|(regs_q[`IDX_G1][`POS_SUB_FLAGS +: 4] & regs_q[`IDX_G1][3:0])) begin
			regs_d[`IDX_C1][`POS_GRP1_FLAG] = 1'b1;
		end
		if (|(regs_q[`IDX_G2][`POS_SUB_FLAGS +: 4] & regs_q[`IDX_G2][3:0])) begin
			regs_d[`IDX_C1][`POS_GRP2_FLAG] = 1'b1;
		end

		// Request built from next values so it never lags the flags
		pend  = pending(regs_d[`IDX_C0], regs_d[`IDX_C1], regs_d[`IDX_C2],
			regs_d[`IDX_C3]);
		req_d = regs_d[`IDX_C0][`POS_GLOBAL_EN] & (|pend);
		vec_d = vec_q;
		for (int v = 11; v >= 0; v--) begin
			if (pend[v]) vec_d = vec_t'(v[3:0]);
		end
		wake_d = ((regs_d[`IDX_C0] | regs_d[`IDX_C1] | regs_d[`IDX_C2]
			| regs_d[`IDX_C3]) & 8'hf0) != 8'h00;
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 8; i++) begin
				regs_q[i] <= `REG_RESET;
			end
			pin_prev_q <= 2'b00;
			prev_ok_q  <= 1'b0;
			prdata_q   <= 32'h0000_0000;
			slverr_q   <= 1'b0;
			req_q      <= 1'b0;
			vec_q      <= VEC_PIN0;
			wake_q     <= 1'b0;
			fresh_q    <= 1'b0;
		end else if (ce) begin
			for (int i = 0; i < 8; i++) begin
				regs_q[i] <= regs_d[i];
			end
			pin_prev_q <= ext_irq_pin;
			prev_ok_q  <= 1'b1;
			prdata_q   <= prdata_d;
			slverr_q   <= slverr_d;
			req_q      <= req_d;
			vec_q      <= vec_d;
			wake_q     <= wake_d;
			fresh_q    <= fresh_d;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	assign pend_now = pending(regs_q[`IDX_C0], regs_q[`IDX_C1], regs_q[`IDX_C2],
		regs_q[`IDX_C3]);

	global_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		irq_req |-> regs_q[`IDX_C0][`POS_GLOBAL_EN])
		else $error("request while global enable is off");

	ack_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce && irq_ack && irq_req |=> !regs_q[`IDX_C0][`POS_GLOBAL_EN])
		else $error("global enable not cleared on service");

	pin0_ack_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce && irq_ack && irq_req && irq_vec == VEC_PIN0 && !pin_hit[0]
		|=> !regs_q[`IDX_C0][`POS_PIN0_FLAG])
		else $error("pin 0 flag not cleared on service");

	rise_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce && prev_ok_q && regs_q[`IDX_EDGE][1:0] == `EDGE_RISE
		&& $rose(ext_irq_pin[0]) |=> regs_q[`IDX_C0][`POS_PIN0_FLAG])
		else $error("rising edge on pin 0 missed");

	fall_only_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce && regs_q[`IDX_EDGE][3:2] == `EDGE_FALL && !regs_q[`IDX_C2][`POS_PIN1_FLAG]
		&& !(psel && penable && pwrite) && $rose(ext_irq_pin[1])
		|=> !regs_q[`IDX_C2][`POS_PIN1_FLAG])
		else $error("pin 1 flag set on wrong edge");

	disabled_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce && events.adc && !regs_q[`IDX_C1][`POS_ADC_EN]
		|=> regs_q[`IDX_C1][`POS_ADC_FLAG])
		else $error("adc flag lost while disabled");

	wake_any_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce && events.nfc |=> wake)
		else $error("wake not raised by set flag");

	highest_a: assert property (@(posedge pclk) disable iff (!presetn)
		irq_req |-> pend_now[irq_vec] && ((pend_now & ((12'h001 << irq_vec) - 12'h001))
		== 12'h000))
		else $error("presented vector is not the highest pending");

	edge_read_a: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && pready && !pwrite && paddr == `OFS_EXT_EDGE_SELECT
		|-> prdata[31:4] == 28'h0)
		else $error("unimplemented edge bits read nonzero");

	reset_zero_a: assert property (@(posedge pclk)
		$rose(presetn) |-> regs_q[`IDX_C1] == 8'h00 && !irq_req)
		else $error("state not zero after reset");

	pin1_ack_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce && irq_ack && irq_req && irq_vec == VEC_PIN1 && !pin_hit[1]
		|=> !regs_q[`IDX_C2][`POS_PIN1_FLAG])
		else $error("pin 1 flag not cleared on service");

	cmp_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce && events.cmp |=> regs_q[`IDX_C0][`POS_CMP_FLAG])
		else $error("comparator flag not set by its event");

	tick0_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce && events.tick0 |=> regs_q[`IDX_C1][`POS_TICK0_FLAG])
		else $error("tick 0 flag not set by its event");

	group_feed_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce && |(regs_q[`IDX_G2][5:4] & regs_q[`IDX_G2][1:0])
		|=> regs_q[`IDX_C1][`POS_GRP2_FLAG])
		else $error("group 2 flag not fed by an enabled sub-flag");

	idle_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		pend_now == 12'h000 |-> !irq_req)
		else $error("request without an enabled pending flag");

	// Pin history only moves with ce, so edge checks want a running cycle before
	pin0_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce && regs_q[`IDX_EDGE][1:0] == `EDGE_OFF && !regs_q[`IDX_C0][`POS_PIN0_FLAG]
		&& !(psel && penable && pwrite) |=> !regs_q[`IDX_C0][`POS_PIN0_FLAG])
		else $error("pin 0 flag set while its edges are off");

	pin1_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce && $past(ce) && prev_ok_q && regs_q[`IDX_EDGE][3:2] == `EDGE_RISE
		&& $rose(ext_irq_pin[1]) |=> regs_q[`IDX_C2][`POS_PIN1_FLAG])
		else $error("rising edge on pin 1 missed");

	pin0_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce && $past(ce) && prev_ok_q && regs_q[`IDX_EDGE][1:0] == `EDGE_FALL
		&& $fell(ext_irq_pin[0]) |=> regs_q[`IDX_C0][`POS_PIN0_FLAG])
		else $error("falling edge on pin 0 missed");

	pin0_vector_a: assert property (@(posedge pclk) disable iff (!presetn)
		irq_req && irq_vec == VEC_PIN0
		|-> regs_q[`IDX_C0][`POS_PIN0_FLAG] && regs_q[`IDX_C0][`POS_PIN0_EN])
		else $error("pin 0 vector without its flag and enable");

	grp0_vector_a: assert property (@(posedge pclk) disable iff (!presetn)
		irq_req && irq_vec == VEC_GRP0
		|-> regs_q[`IDX_C0][`POS_GRP0_FLAG] && regs_q[`IDX_C0][`POS_GRP0_EN])
		else $error("group 0 vector without its flag and enable");

	write_lands_a: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && pready && pwrite && paddr == `OFS_IRQ_CONTROL_3
		|=> regs_q[`IDX_C3][`POS_NFC_EN] == $past(pwdata[`POS_NFC_EN]))
		else $error("enable write to control 3 lost");

endmodule : irq_ctrl

// File: irq_seq_model.sv
// Purpose: Sequencer stand-in that takes the vectors the block requests
// Assumes: irq_ack is a one-cycle pulse, raised only while irq_req is high
// Notes:   ack_wait sets how long a request sits before it is taken
`timescale 1ns/10ps
module irq_seq_model
	import irq_ctrl_pkg::*;
(
	input  wire logic       pclk,     // System clock
	input  wire logic       presetn,  // Async reset, active low
	input  wire logic       irq_req,  // Request from block
	input  wire vec_t       irq_vec,  // Requested vector
	input  wire logic       take_en,  // Accept requests
	input  wire logic [3:0] ack_wait, // Cycles before ack
	output logic            irq_ack,  // Take pulse
	output vec_t            last_vec, // Vector last taken
	output logic [7:0]      n_taken   // Vectors taken
);
	// ----------------------------------------
	// Take logic
	// ----------------------------------------
	logic [3:0] cnt_q;

	// Skips the ack edge itself: request is still high there
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q    <= 4'h0;
			irq_ack  <= 1'b0;
			last_vec <= VEC_PIN0;
			n_taken  <= 8'h00;
		end else begin
			irq_ack <= 1'b0;
			if (take_en && irq_req && !irq_ack) begin
				if (cnt_q >= ack_wait) begin
					irq_ack  <= 1'b1;
					last_vec <= irq_vec;
					n_taken  <= n_taken + 8'h01;
					cnt_q    <= 4'h0;
				end else begin
					cnt_q <= cnt_q + 4'h1;
				end
			end else begin
				cnt_q <= 4'h0;
			end
		end
	end
endmodule : irq_seq_model

// File: irq_ctrl_tb.sv
// Purpose: Self-checking bench of irq_ctrl over APB, pins and events
// Assumes: APB slave may stall while ce is low; flags read back through registers
// Notes:   Sequencer model takes vectors only while take_en is set
`timescale 1ns/10ps
`include "irq_ctrl_defs.svh"
module irq_ctrl_tb
	import irq_ctrl_pkg::*;
;
	// ----------------------------------------
	// Bench plumbing
	// ----------------------------------------
	logic        pclk = 1'b0, presetn = 1'b0, ce = 1'b1, take_en = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
	logic        irq_req, irq_ack, wake, err;
	logic [1:0]  pins = 2'b00;
	logic [3:0]  ack_wait = 4'h0;
	logic [7:0]  n_taken;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	src_events_t events = '0;
	vec_t        irq_vec, last_vec;
	int          err_count = 0, n_tests = 0;
	logic [11:0] ofs [8] = '{`OFS_EXT_EDGE_SELECT, `OFS_IRQ_CONTROL_0, `OFS_IRQ_CONTROL_1,
		`OFS_IRQ_CONTROL_2, `OFS_IRQ_CONTROL_3, `OFS_GROUP_IRQ_0, `OFS_GROUP_IRQ_1,
		`OFS_GROUP_IRQ_2};
	logic [7:0]  msk [8] = '{8'h0f, 8'h7f, 8'hff, 8'hff, 8'h11, 8'h33, 8'hff, 8'h33};
	// Per event bit, lvd first: register index, flag bit
	logic [7:0]  evt [15] = '{8'h74, 8'h75, 8'h67, 8'h66, 8'h65, 8'h64, 8'h55, 8'h54,
		8'h44, 8'h37, 8'h36, 8'h34, 8'h27, 8'h26, 8'h15};
	logic [7:0]  gfl [3] = '{8'h40, 8'h10, 8'h20};
	logic [7:0]  gen_en [3] = '{8'h08, 8'h01, 8'h02};
	int          gev [3] = '{7, 5, 0};

	always #10 pclk = ~pclk;

	irq_ctrl dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_irq_pin(pins), .events(events), .irq_req(irq_req),
		.irq_vec(irq_vec), .irq_ack(irq_ack), .wake(wake));
	irq_seq_model seq (.pclk(pclk), .presetn(presetn), .irq_req(irq_req), .irq_vec(irq_vec),
		.take_en(take_en), .ack_wait(ack_wait), .irq_ack(irq_ack), .last_vec(last_vec),
		.n_taken(n_taken));

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("BAD %s exp %h got %h", what, exp, got);
			err_count++;
		end
	endtask : chk

	task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d,
		output logic [31:0] rd_v, output logic rd_e);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd_v = prdata;
		rd_e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] v;
		logic        e;
		apb(a, 1'b1, d, v, e);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string what);
		logic [31:0] v;
		logic        e;
		apb(a, 1'b0, 8'h00, v, e);
		chk(what, {24'h0, exp}, v);
		chk("no error", 32'h0, {31'h0, e});
	endtask : rd

	task automatic pulse(input src_events_t e);
		@(posedge pclk);
		events <= e;
		@(posedge pclk);
		events <= '0;
	endtask : pulse

	task automatic pin(input int p, input logic v);
		@(posedge pclk);
		pins[p] <= v;
		repeat (2) @(posedge pclk);
	endtask : pin

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : stop_test

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (5000) @(posedge pclk);
		err_count++;
		$display("BAD watchdog exp finish got hang");
		stop_test();
	end

	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 8; i++) rd(ofs[i], 8'h00, "reset value");
		chk("reset outputs", 32'h0, {30'h0, irq_req, wake});
		apb(12'h020, 1'b1, 8'hff, rdat, err);
		chk("unmapped error", 32'h1, {31'h0, err});
		$display("test reset done");
		for (int i = 0; i < 8; i++) wr(ofs[i], 8'hff);
		for (int i = 0; i < 8; i++) rd(ofs[i], msk[i], "ones");
		chk("top vector", {28'h1, VEC_PIN0}, {27'h0, irq_req, irq_vec});
		chk("wake", 32'h1, {31'h0, wake});
		// Groups first: a group flag only clears once its sub-flags are gone
		for (int i = 7; i >= 0; i--) wr(ofs[i], 8'h00);
		for (int i = 0; i < 8; i++) rd(ofs[i], 8'h00, "cleared");
		$display("test access done");
		for (int p = 0; p < 2; p++) begin
			for (int s = 0; s < 4; s++) begin
				wr(ofs[0], 8'(s << (2 * p)));
				pin(p, 1'b1);
				rd(ofs[p ? 3 : 1], s[0] ? 8'h10 << p : 8'h00, "rise flag");
				chk("pin wake", 32'(s[0]), {31'h0, wake});
				wr(ofs[p ? 3 : 1], 8'h00);
				pin(p, 1'b0);
				rd(ofs[p ? 3 : 1], s[1] ? 8'h10 << p : 8'h00, "fall flag");
				wr(ofs[p ? 3 : 1], 8'h00);
			end
		end
		$display("test edges done");
		for (int i = 0; i < 15; i++) begin
			pulse(src_events_t'(15'h1 << i));
			rd(ofs[evt[i][7:4]], 8'h01 << evt[i][3:0], "event flag");
			wr(ofs[evt[i][7:4]], 8'h00);
		end
		$display("test events done");
		wr(ofs[1], 8'h04);
		wr(ofs[2], 8'h04);
		pulse(src_events_t'(15'h6000));
		repeat (2) @(posedge pclk);
		chk("gated", 32'h0, {31'h0, irq_req});
		wr(ofs[1], 8'h25);
		repeat (2) @(posedge pclk);
		chk("cmp first", {28'h1, VEC_CMP}, {27'h0, irq_req, irq_vec});
		ack_wait <= 4'h3;
		take_en  <= 1'b1;
		repeat (8) @(posedge pclk);
		chk("cmp taken", {19'h0, 8'h01, 1'b0, VEC_CMP}, {19'h0, n_taken, irq_req, last_vec});
		pulse(src_events_t'(15'h1000));
		rd(ofs[2], 8'hc4, "recorded");
		wr(ofs[2], 8'h00);
		ack_wait <= 4'h0;
		for (int p = 0; p < 2; p++) begin
			wr(ofs[0], p ? 8'h04 : 8'h01);
			wr(ofs[p ? 3 : 1], 8'h02);
			wr(ofs[1], p ? 8'h01 : 8'h03);
			pin(p, 1'b1);
			repeat (4) @(posedge pclk);
			chk("pin taken", 32'(p ? VEC_PIN1 : VEC_PIN0), 32'(last_vec));
			rd(ofs[1], p ? 8'h00 : 8'h02, "serviced c0");
			rd(ofs[3], p ? 8'h02 : 8'h00, "serviced c2");
			pin(p, 1'b0);
			wr(ofs[p ? 3 : 1], 8'h00);
		end
		wr(ofs[0], 8'h00);
		take_en <= 1'b0;
		$display("test delivery done");
		for (int g = 0; g < 3; g++) begin
			wr(ofs[5 + g], 8'h01);
			pulse(src_events_t'(15'h1 << gev[g]));
			rd(ofs[g ? 2 : 1], gfl[g], "group flag");
			wr(ofs[g ? 2 : 1], gfl[g] | gen_en[g]);
			wr(ofs[1], g ? 8'h01 : 8'h49);
			repeat (2) @(posedge pclk);
			chk("group vec", 32'h10 | (32'(VEC_GRP0) + g), {27'h0, irq_req, irq_vec});
			wr(ofs[5 + g], 8'h00);
			wr(ofs[2], 8'h00);
			wr(ofs[1], 8'h00);
		end
		$display("test groups done");
		// Clock enable low must stall the transfer, not drop it
		ce <= 1'b0;
		fork
			wr(ofs[4], 8'h11);
			begin
				repeat (5) @(posedge pclk);
				chk("stalled", 32'h0, {31'h0, pready});
				ce <= 1'b1;
			end
		join
		ce <= 1'b0;
		fork
			rd(ofs[4], 8'h11, "stalled read");
			begin
				repeat (5) @(posedge pclk);
				ce <= 1'b1;
			end
		join
		wr(ofs[4], 8'h00);
		$display("test stall done");
		stop_test();
	end
endmodule : irq_ctrl_tb
